// ===== src/lops_pkg.sv
// Purpose: shared constants of the linked one-shot pulse timer
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes:   field positions and reset values used by the timer and trigger input files, not by the channel
package lops_pkg;
    // widths
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    localparam int BUS_W  = 32;
    localparam int PSC_W  = 4;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_TRIG    = 8'h04;
    localparam logic [7:0] ADDR_STATUS  = 8'h08;
    localparam logic [7:0] ADDR_MODE    = 8'h0C;
    localparam logic [7:0] ADDR_MRELOAD = 8'h10;
    localparam logic [7:0] ADDR_SRELOAD = 8'h14;
    localparam logic [7:0] ADDR_MCOUNT  = 8'h18;
    localparam logic [7:0] ADDR_SCOUNT  = 8'h1C;
    localparam logic [7:0] ADDR_OUTCFG  = 8'h20;

    // control: timer_unit_clock_on
    localparam int BIT_UNIT_ON = 0;
    // trigger register, write-only, self-clearing
    localparam int BIT_M_START = 0;
    localparam int BIT_S_START = 1;
    localparam int BIT_M_STOP  = 2;
    localparam int BIT_S_STOP  = 3;
    // status register
    localparam int BIT_M_EN    = 0;
    localparam int BIT_S_EN    = 1;
    localparam int BIT_OUT_LVL = 2;
    localparam int BIT_PAIR_OK = 3;
    // channel_mode_cfg fields
    localparam int BIT_EDGE_LO = 0;
    localparam int BIT_EDGE_HI = 1;
    localparam int BIT_FILTER  = 2;
    localparam int PSC_LSB     = 3;
    localparam int BIT_LEADER  = 7;
    localparam int MODE_W      = 8;
    // output configuration fields
    localparam int BIT_OUT_VAL = 0;
    localparam int BIT_GATE    = 1;
    localparam int BIT_POL     = 2;
    localparam int BIT_ROLE    = 3;
    localparam int OUTCFG_W    = 4;

    // edge select encodings {edge_select_high, edge_select_low}
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;

    // reset values
    localparam logic [MODE_W-1:0]   RST_MODE   = 8'h00;
    localparam logic [OUTCFG_W-1:0] RST_OUTCFG = 4'h0;
    localparam logic [DATA_W-1:0]   RST_COUNT  = 16'h0000;
    localparam logic [15:0]         PSC_ONE    = 16'h0001;
    localparam logic [BUS_W-1:0]    RD_ZERO    = 32'h0000_0000;
endpackage : lops_pkg

// ===== src/lops_trig_in.sv
// Purpose: optional noise filter and edge select on the trigger input pin
// Assumes: pin is synchronous to clk
// Notes:   filter passes a level only after two equal consecutive samples
`timescale 1ns/1ps
module lops_trig_in (
    input  wire logic       clk,
    input  wire logic       clr,
    input  wire logic       pin,
    input  wire logic       filter_en,
    input  wire logic [1:0] edge_sel,
    output logic            edge_pulse
);
    import lops_pkg::*;

    logic samp_reg, samp_next;
    logic lvl_reg,  lvl_next;
    logic edge_reg, edge_next;

    // filtered level and edge decode
    always_comb begin
        samp_next = pin;
        lvl_next  = lvl_reg;
        if (!filter_en || pin == samp_reg) begin
            lvl_next = pin;
        end
        unique case (edge_sel)
            EDGE_FALL: edge_next = lvl_reg && !lvl_next;
            EDGE_RISE: edge_next = !lvl_reg && lvl_next;
            default:   edge_next = lvl_reg != lvl_next;
        endcase
    end

    // state registers
    always_ff @(posedge clk) begin
        if (clr) begin
            samp_reg <= 1'b0;
            lvl_reg  <= 1'b0;
            edge_reg <= 1'b0;
        end else begin
            samp_reg <= samp_next;
            lvl_reg  <= lvl_next;
            edge_reg <= edge_next;
        end
    end

    assign edge_pulse = edge_reg;
endmodule : lops_trig_in

// ===== src/lops_channel.sv
// Purpose: one single-count down counter channel
// Assumes: tick is a one-cycle count clock enable
// Notes:   a trigger on a tick loads at once, else it is latched for the next tick
`timescale 1ns/1ps
module lops_channel #(
    parameter int CNT_W = 16
) (
    input  wire logic             clk,
    input  wire logic             clr,
    input  wire logic             tick,
    input  wire logic             enable,
    input  wire logic             trigger,
    input  wire logic [CNT_W-1:0] reload,
    output logic      [CNT_W-1:0] count,
    output logic                  active,
    output logic                  pending,
    output logic                  irq,
    output logic                  load
);
    localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic             act_reg, act_next;
    logic             pend_reg, pend_next;
    logic             irq_reg, irq_next;
    logic             load_reg, load_next;

    // trigger latch, load and down count; frozen while disabled
    always_comb begin
        cnt_next  = cnt_reg;
        act_next  = act_reg;
        pend_next = pend_reg;
        irq_next  = 1'b0;
        load_next = 1'b0;
        if (!enable) begin
            pend_next = 1'b0;
        end else begin
            if (trigger) begin
                pend_next = 1'b1;
            end
            if (tick) begin
                // a trigger on a tick is taken at once, keeping delay exact
                if (pend_reg || trigger) begin
                    cnt_next  = reload;
                    act_next  = reload != '0;
                    irq_next  = reload == '0;
                    load_next = 1'b1;
                    pend_next = 1'b0;
                end else if (act_reg) begin
                    cnt_next = cnt_reg - CNT_ONE;
                    if (cnt_reg == CNT_ONE) begin
                        act_next = 1'b0;
                        irq_next = 1'b1;
                    end
                end
            end
        end
    end

    // state registers
    always_ff @(posedge clk) begin
        if (clr) begin
            cnt_reg  <= '0;
            act_reg  <= 1'b0;
            pend_reg <= 1'b0;
            irq_reg  <= 1'b0;
            load_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            act_reg  <= act_next;
            pend_reg <= pend_next;
            irq_reg  <= irq_next;
            load_reg <= load_next;
        end
    end

    assign count   = cnt_reg;
    assign active  = act_reg;
    assign pending = pend_reg;
    assign irq     = irq_reg;
    assign load    = load_reg;
endmodule : lops_channel

// ===== src/lops_pulse_timer.sv
// Purpose: linked master/slave channel pair giving a delayed one-shot pulse
// Assumes: one 25 MHz clock, synchronous active-high reset, sync pin input
// Notes:   count clock is a prescaled one-cycle enable of clk
//
// Notes on behaviour
// - delay is master reload plus one tick and one clk cycle
// - pulse width is slave reload ticks
// - master trigger loads reload, then counts down
// - master zero raises irq, waits next trigger
// - master irq starts slave load and count
// - slave zero raises irq, waits master irq
// - output active one tick plus one clk cycle after master irq
// - software start bit acts as trigger
// - start bits set both enables, self-clear
// - stop bits clear enables, freeze counters, output
// - polarity bit zero high, one low
// - role bit selects master or slave output
// - gate bit lets counting drive output
// - stopped channel keeps output register level
// - counters readable anytime, status register shows enables, output level, pairing
// - unit off ignores writes except to control, resets everything
// - master even channel, slave higher bounded
`timescale 1ns/1ps
module lops_pulse_timer #(
    parameter int UNIT      = 0,
    parameter int MASTER_CH = 0,
    parameter int SLAVE_CH  = 1,
    parameter int CNT_W     = lops_pkg::DATA_W
) (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic [lops_pkg::ADDR_W-1:0] addr,
    input  wire logic [lops_pkg::BUS_W-1:0]  wdata,
    input  wire logic                        we,
    input  wire logic                        re,
    input  wire logic                        trig_pin,
    output logic      [lops_pkg::BUS_W-1:0]  rdata,
    output logic                             pulse_out,
    output logic                             master_expire_irq,
    output logic                             slave_expire_irq
);
    import lops_pkg::*;

    // pairing legality, shown in status
    localparam logic PAIR_OK = (MASTER_CH % 2 == 0) && (MASTER_CH <= 6)
        && (SLAVE_CH > MASTER_CH) && (SLAVE_CH <= ((UNIT == 0) ? 3 : 7));
    localparam logic LEADER_FIXED = MASTER_CH == 0;

    logic                on_reg,     on_next;
    logic [MODE_W-1:0]   mode_reg,   mode_next;
    logic [OUTCFG_W-1:0] outcfg_reg, outcfg_next;
    logic [CNT_W-1:0]    mrel_reg,   mrel_next;
    logic [CNT_W-1:0]    srel_reg,   srel_next;
    logic                men_reg,    men_next;
    logic                sen_reg,    sen_next;
    logic                out_reg,    out_next;
    logic [BUS_W-1:0]    rdata_reg,  rdata_next;
    logic [15:0]         psc_reg,    psc_next;
    logic                tick_reg,   tick_next;

    logic             unit_clr;
    logic             wr;
    logic             m_start, s_start, m_stop, s_stop;
    logic             pin_edge, m_trig;
    logic [CNT_W-1:0] m_cnt, s_cnt;
    logic             m_act, s_act, m_pend, s_pend;
    logic             m_irq, s_irq, m_load, s_load;
    logic             active_lvl;
    logic [15:0]      psc_limit;

    // unit off holds every block in reset, writes gated
    assign unit_clr = rst || !on_reg;
    assign wr       = we && on_reg;
    assign m_start  = wr && addr == ADDR_TRIG && wdata[BIT_M_START];
    assign s_start  = wr && addr == ADDR_TRIG && wdata[BIT_S_START];
    assign m_stop   = wr && addr == ADDR_TRIG && wdata[BIT_M_STOP];
    assign s_stop   = wr && addr == ADDR_TRIG && wdata[BIT_S_STOP];

    // start trigger: pin edge or software start while enabled
    assign m_trig     = men_reg && (pin_edge || m_start);
    assign active_lvl = !outcfg_reg[BIT_POL];
    assign psc_limit  = (PSC_ONE << mode_reg[PSC_LSB +: PSC_W]) - PSC_ONE;

    lops_trig_in u_trig_in (
        .clk        (clk),
        .clr        (unit_clr),
        .pin        (trig_pin),
        .filter_en  (mode_reg[BIT_FILTER]),
        .edge_sel   ({mode_reg[BIT_EDGE_HI], mode_reg[BIT_EDGE_LO]}),
        .edge_pulse (pin_edge)
    );

    // delay channel
    lops_channel #(.CNT_W(CNT_W)) u_master (
        .clk     (clk),
        .clr     (unit_clr),
        .tick    (tick_reg),
        .enable  (men_reg),
        .trigger (m_trig),
        .reload  (mrel_reg),
        .count   (m_cnt),
        .active  (m_act),
        .pending (m_pend),
        .irq     (m_irq),
        .load    (m_load)
    );

    // pulse width channel, started by the master expiry
    lops_channel #(.CNT_W(CNT_W)) u_slave (
        .clk     (clk),
        .clr     (unit_clr),
        .tick    (tick_reg),
        .enable  (sen_reg),
        .trigger (m_irq),
        .reload  (srel_reg),
        .count   (s_cnt),
        .active  (s_act),
        .pending (s_pend),
        .irq     (s_irq),
        .load    (s_load)
    );

    // count clock prescaler
    always_comb begin
        tick_next = psc_reg == psc_limit;
        psc_next  = tick_next ? 16'h0000 : psc_reg + PSC_ONE;
    end

    // configuration and enable bits
    always_comb begin
        on_next     = on_reg;
        mode_next   = mode_reg;
        outcfg_next = outcfg_reg;
        mrel_next   = mrel_reg;
        srel_next   = srel_reg;
        men_next    = men_reg;
        sen_next    = sen_reg;
        if (we && addr == ADDR_CTRL) begin
            on_next = wdata[BIT_UNIT_ON];
        end
        if (wr && addr == ADDR_MODE) begin
            mode_next = wdata[MODE_W-1:0];
            if (LEADER_FIXED) begin
                mode_next[BIT_LEADER] = 1'b0;
            end
        end
        if (wr && addr == ADDR_OUTCFG) begin
            outcfg_next = wdata[OUTCFG_W-1:0];
        end
        if (wr && addr == ADDR_MRELOAD) begin
            mrel_next = wdata[CNT_W-1:0];
        end
        if (wr && addr == ADDR_SRELOAD) begin
            srel_next = wdata[CNT_W-1:0];
        end
        if (m_start) begin
            men_next = 1'b1;
        end
        if (s_start) begin
            sen_next = 1'b1;
        end
        if (m_stop) begin
            men_next = 1'b0;
        end
        if (s_stop) begin
            sen_next = 1'b0;
        end
    end

    // output pin level; counting events beat a software write
    always_comb begin
        out_next = out_reg;
        if (wr && addr == ADDR_OUTCFG) begin
            out_next = wdata[BIT_OUT_VAL];
        end
        if (outcfg_reg[BIT_GATE]) begin
            if (outcfg_reg[BIT_ROLE]) begin
                if (s_load && s_act) begin
                    out_next = active_lvl;
                end
                if (s_irq) begin
                    out_next = !active_lvl;
                end
            end else if (m_irq) begin
                out_next = !out_reg;
            end
        end
    end

    // read mux, data valid the cycle after the strobe only
    always_comb begin
        rdata_next = RD_ZERO;
        if (re) begin
            unique case (addr)
                ADDR_CTRL:    rdata_next[BIT_UNIT_ON] = on_reg;
                ADDR_STATUS: begin
                    rdata_next[BIT_M_EN]    = men_reg;
                    rdata_next[BIT_S_EN]    = sen_reg;
                    rdata_next[BIT_OUT_LVL] = out_reg;
                    rdata_next[BIT_PAIR_OK] = PAIR_OK;
                end
                ADDR_MODE:    rdata_next[MODE_W-1:0]   = mode_reg;
                ADDR_OUTCFG: begin
                    rdata_next[OUTCFG_W-1:0] = outcfg_reg;
                    rdata_next[BIT_OUT_VAL]  = out_reg;
                end
                ADDR_MRELOAD: rdata_next[CNT_W-1:0] = mrel_reg;
                ADDR_SRELOAD: rdata_next[CNT_W-1:0] = srel_reg;
                ADDR_MCOUNT:  rdata_next[CNT_W-1:0] = m_cnt;
                ADDR_SCOUNT:  rdata_next[CNT_W-1:0] = s_cnt;
                default:      rdata_next = RD_ZERO;
            endcase
        end
    end

    // unit enable and read data, reset only by system reset
    always_ff @(posedge clk) begin
        if (rst) begin
            on_reg    <= 1'b0;
            rdata_reg <= RD_ZERO;
        end else begin
            on_reg    <= on_next;
            rdata_reg <= rdata_next;
        end
    end

    // unit state, reset while the unit clock is off
    always_ff @(posedge clk) begin
        if (unit_clr) begin
            mode_reg   <= RST_MODE;
            outcfg_reg <= RST_OUTCFG;
            mrel_reg   <= RST_COUNT;
            srel_reg   <= RST_COUNT;
            men_reg    <= 1'b0;
            sen_reg    <= 1'b0;
            out_reg    <= 1'b0;
            psc_reg    <= 16'h0000;
            tick_reg   <= 1'b0;
        end else begin
            mode_reg   <= mode_next;
            outcfg_reg <= outcfg_next;
            mrel_reg   <= mrel_next;
            srel_reg   <= srel_next;
            men_reg    <= men_next;
            sen_reg    <= sen_next;
            out_reg    <= out_next;
            psc_reg    <= psc_next;
            tick_reg   <= tick_next;
        end
    end

    assign rdata             = rdata_reg;
    assign pulse_out         = out_reg;
    assign master_expire_irq = m_irq;
    assign slave_expire_irq  = s_irq;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !on_reg);

    sequence seq_master_load;
        tick_reg && men_reg && (m_pend || m_trig);
    endsequence
    sequence seq_slave_load;
        tick_reg && sen_reg && (s_pend || m_irq);
    endsequence

    a_master_load_value: assert property (
        seq_master_load |=> m_load && m_cnt == $past(mrel_reg))
        else $error("master did not load its reload value");
    a_master_expire_hold: assert property (
        m_irq |-> m_cnt == '0 && !m_act)
        else $error("master irq without stopped zero count");
    a_slave_start_irq: assert property (
        m_irq && sen_reg && !s_stop |=> s_pend || s_load)
        else $error("master irq did not arm the slave");
    a_slave_load_value: assert property (
        seq_slave_load ##1 s_load |-> s_cnt == $past(srel_reg))
        else $error("slave did not load its reload value");
    a_slave_expire_hold: assert property (
        s_irq |-> s_cnt == '0 && !s_act)
        else $error("slave irq without stopped zero count");
    a_pulse_start: assert property (
        s_load && s_act && outcfg_reg[BIT_GATE] && outcfg_reg[BIT_ROLE] && !s_irq
        |=> out_reg == $past(active_lvl))
        else $error("pulse did not reach active level");
    a_pulse_end: assert property (
        s_irq && outcfg_reg[BIT_GATE] && outcfg_reg[BIT_ROLE]
        |=> out_reg == $past(outcfg_reg[BIT_POL]))
        else $error("pulse did not return to inactive level");
    a_sw_trigger: assert property (
        m_start && men_reg && !m_stop |=> m_pend || m_load)
        else $error("software start did not act as trigger");
    a_start_enables: assert property (
        m_start && s_start && !m_stop && !s_stop |=> men_reg && sen_reg)
        else $error("start bits did not set enables");
    a_stop_freeze: assert property (
        !men_reg && !sen_reg && $past(!men_reg && !sen_reg)
        |-> $stable(m_cnt) && $stable(s_cnt))
        else $error("counter moved while stopped");
    a_stopped_output: assert property (
        !men_reg && !sen_reg && !(wr && addr == ADDR_OUTCFG) |=> $stable(out_reg))
        else $error("output changed while stopped");
    a_gate_blocks: assert property (
        !outcfg_reg[BIT_GATE] && !(wr && addr == ADDR_OUTCFG) |=> $stable(out_reg))
        else $error("counting drove a gated output");
    a_disabled_ignore: assert property (
        !men_reg |=> !m_pend && !m_act || $stable(m_cnt))
        else $error("disabled master accepted a trigger");
    a_unit_off_reset: assert property (@(posedge clk) disable iff (rst)
        !on_reg |=> !out_reg && !men_reg && !sen_reg && m_cnt == '0)
        else $error("unit off did not clear the timer");
endmodule : lops_pulse_timer

// ===== tb/lops_pin_model.sv
// Purpose: trigger source on the input pin and pulse load on the output pin
// Assumes: pin levels change just after a rising clk edge
// Notes:   measures delay from arming to pulse and the pulse width in clk cycles
`timescale 1ns/1ps
module lops_pin_model (
    input  wire logic clk,
    input  wire logic fire,
    input  wire logic use_pin,
    input  wire logic active_high,
    input  wire logic pulse_out,
    output logic      trig_pin,
    output int        delay_cyc,
    output int        width_cyc,
    output int        pulses
);
    int   hold_cnt;
    int   elapsed;
    int   wide;
    logic armed;
    logic in_pulse;

    initial begin
        trig_pin  = 1'b0;
        hold_cnt  = 0;
        armed     = 1'b0;
        in_pulse  = 1'b0;
        pulses    = 0;
        delay_cyc = 0;
        width_cyc = 0;
    end

    // rising edge held four samples so the noise filter passes it
    always @(posedge clk) begin
        if (fire && use_pin) begin
            trig_pin <= 1'b1;
            hold_cnt <= 4;
        end else if (hold_cnt > 0) begin
            hold_cnt <= hold_cnt - 1;
            if (hold_cnt == 1) trig_pin <= 1'b0;
        end
        // load side: time the active level once armed
        if (fire) begin
            armed   <= 1'b1;
            elapsed <= 0;
        end else if (armed) begin
            elapsed <= elapsed + 1;
            if (!in_pulse && pulse_out === active_high) begin
                in_pulse  <= 1'b1;
                delay_cyc <= elapsed;
                wide      <= 1;
            end else if (in_pulse && pulse_out === active_high) begin
                wide <= wide + 1;
            end else if (in_pulse) begin
                in_pulse  <= 1'b0;
                armed     <= 1'b0;
                width_cyc <= wide;
                pulses    <= pulses + 1;
            end
        end
    end
endmodule : lops_pin_model

// ===== tb/test_lops_pulse_timer.sv
// Purpose: register-level tests of the linked one-shot pulse timer
// Assumes: prescaler 0 unless set, rising edge trigger, filter on
// Notes:   expectations follow the register map of the package
`timescale 1ns/1ps
module test_lops_pulse_timer;
    import lops_pkg::*;
    logic        clk = 0, rst = 1, we = 0, re = 0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v, w;
    logic        trig_pin, pulse_out, m_irq, s_irq;
    logic        fire = 0, use_pin = 0, act_hi = 1, last_out = 0;
    int          delay_cyc, width_cyc, pulses, d3;
    int          miscompares = 0, compares = 0;
    int          cyc = 0, m_irqs = 0, s_irqs = 0, m_at = 0, act_at = 0, flips = 0;

    lops_pulse_timer lops_pulse_timer_i (.clk(clk), .rst(rst), .addr(addr),
        .wdata(wdata), .we(we), .re(re), .trig_pin(trig_pin), .rdata(rdata),
        .pulse_out(pulse_out), .master_expire_irq(m_irq), .slave_expire_irq(s_irq));
    lops_pin_model lops_pin_model_i (.clk(clk), .fire(fire), .use_pin(use_pin),
        .active_high(act_hi), .pulse_out(pulse_out), .trig_pin(trig_pin),
        .delay_cyc(delay_cyc), .width_cyc(width_cyc), .pulses(pulses));

    // 25 MHz clock
    always #20 clk = ~clk;

    // irq and output event monitor
    always @(posedge clk) begin
        cyc      <= cyc + 1;
        last_out <= pulse_out;
        if (m_irq === 1'b1) begin
            m_irqs <= m_irqs + 1;
            m_at   <= cyc;
        end
        if (s_irq === 1'b1) s_irqs <= s_irqs + 1;
        if (pulse_out !== last_out) flips <= flips + 1;
        if (pulse_out === 1'b1 && last_out === 1'b0) act_at <= cyc;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        we    <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        re   <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        rd(a, v);
        chk(v, exp);
    endtask : rdc

    // arm the load and optionally raise the pin
    task arm(input logic p);
        @(posedge clk);
        fire    <= 1'b1;
        use_pin <= p;
        @(posedge clk);
        fire <= 1'b0;
    endtask : arm

    task wait_s(input int n);
        for (int i = 0; i < 3000 && s_irqs < n; i++) @(posedge clk);
        repeat (3) @(posedge clk);
    endtask : wait_s

    task end_of_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        $display("unexpected at %0t: got %h expected %h", $time, cyc, 0);
        end_of_test();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rdc(ADDR_STATUS, 32'h8);
        rdc(8'h40, 32'h0);
        wr(ADDR_MRELOAD, 32'h5);
        rdc(ADDR_MRELOAD, 32'h0);
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_MODE, 32'h85);
        rdc(ADDR_MODE, 32'h05);
        wr(ADDR_MRELOAD, 32'h3);
        wr(ADDR_SRELOAD, 32'h4);
        wr(ADDR_OUTCFG, 32'h0A);
        wr(ADDR_TRIG, 32'h3);
        rdc(ADDR_STATUS, 32'hB);
        rdc(ADDR_TRIG, 32'h0);
        rdc(ADDR_MCOUNT, 32'h0);
        // pin triggered pulse
        arm(1'b1);
        wait_s(1);
        chk(width_cyc, 4);
        chk(m_irqs, 1);
        chk(s_irqs, 1);
        chk(act_at - m_at, 2);
        rdc(ADDR_MCOUNT, 32'h0);
        d3 = delay_cyc;
        wr(ADDR_MRELOAD, 32'h9);
        arm(1'b1);
        wait_s(2);
        chk(delay_cyc - d3, 6);
        // software start while enabled
        arm(1'b0);
        wr(ADDR_TRIG, 32'h1);
        wait_s(3);
        chk(pulses, 3);
        chk(width_cyc, 4);
        // prescaler 1 doubles the count clock period
        wr(ADDR_TRIG, 32'hC);
        wr(ADDR_MODE, 32'h0D);
        wr(ADDR_TRIG, 32'h3);
        arm(1'b1);
        wait_s(4);
        chk(width_cyc, 8);
        // active low pulse
        wr(ADDR_TRIG, 32'hC);
        wr(ADDR_MODE, 32'h05);
        act_hi <= 1'b0;
        wr(ADDR_OUTCFG, 32'h0F);
        wr(ADDR_TRIG, 32'h3);
        chk(pulse_out, 1);
        arm(1'b1);
        wait_s(5);
        chk(width_cyc, 4);
        chk(pulse_out, 1);
        // stop in mid pulse
        wr(ADDR_TRIG, 32'hC);
        act_hi <= 1'b1;
        wr(ADDR_OUTCFG, 32'h0A);
        wr(ADDR_SRELOAD, 32'h3C);
        wr(ADDR_TRIG, 32'h3);
        arm(1'b1);
        for (int i = 0; i < 100 && pulse_out !== 1'b1; i++) @(posedge clk);
        wr(ADDR_TRIG, 32'hC);
        rd(ADDR_SCOUNT, w);
        repeat (30) @(posedge clk);
        rdc(ADDR_SCOUNT, w);
        chk(pulse_out, 1);
        rdc(ADDR_STATUS, 32'hC);
        arm(1'b1);
        repeat (40) @(posedge clk);
        chk(m_irqs, 6);
        // unit off clears everything
        wr(ADDR_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        chk(pulse_out, 0);
        wr(ADDR_CTRL, 32'h1);
        rdc(ADDR_OUTCFG, 32'h0);
        rdc(ADDR_SRELOAD, 32'h0);
        // gate off: counting leaves the output alone
        wr(ADDR_MRELOAD, 32'h3);
        wr(ADDR_SRELOAD, 32'h4);
        wr(ADDR_OUTCFG, 32'h08);
        wr(ADDR_TRIG, 32'h3);
        d3 = flips;
        arm(1'b1);
        wait_s(6);
        chk(flips - d3, 0);
        chk(s_irqs, 6);
        // master output mode toggles on each master irq
        wr(ADDR_OUTCFG, 32'h02);
        arm(1'b1);
        wait_s(7);
        chk(pulse_out, 1);
        arm(1'b1);
        wait_s(8);
        chk(pulse_out, 0);
        end_of_test();
    end
endmodule : test_lops_pulse_timer
